// ===== hdl/pdoa_pkg.sv
// Shared constants for the protection detection overlap arbiter
`default_nettype none
package pdoa_pkg;
	// Core clock period
	localparam int PDOA_CLK_NS = 50;
	// Qualifier channels
	localparam int PDOA_NCH = 9;
	localparam int CH_OCH_D = 0;
	localparam int CH_OCH_R = 1;
	localparam int CH_ODI_D = 2;
	localparam int CH_ODI_R = 3;
	localparam int CH_OCU_D = 4;
	localparam int CH_SCD_D = 5;
	localparam int CH_OCU_R = 6;
	localparam int CH_XCH_D = 7;
	localparam int CH_XCH_R = 8;
	localparam int PDOA_CW = 24;
	// Delay times in microseconds, per channel
	localparam int PDOA_DLY_US [PDOA_NCH] = '{1000, 1000, 100, 1000, 10000, 300, 1000, 1000, 1000};
	// Least times round up to whole cycles, never below one
	function automatic int pdoa_cyc(input int us);
		int c;
		c = (us * 1000 + PDOA_CLK_NS - 1) / PDOA_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int PDOA_DLY_CYC [PDOA_NCH] = '{
		pdoa_cyc(PDOA_DLY_US[0]), pdoa_cyc(PDOA_DLY_US[1]), pdoa_cyc(PDOA_DLY_US[2]),
		pdoa_cyc(PDOA_DLY_US[3]), pdoa_cyc(PDOA_DLY_US[4]), pdoa_cyc(PDOA_DLY_US[5]),
		pdoa_cyc(PDOA_DLY_US[6]), pdoa_cyc(PDOA_DLY_US[7]), pdoa_cyc(PDOA_DLY_US[8])};
	// Register byte offsets
	localparam logic [11:0] PDOA_OFS_CTRL = 12'h000;
	localparam logic [11:0] PDOA_OFS_STATE = 12'h004;
	localparam logic [11:0] PDOA_OFS_INT_STAT = 12'h008;
	localparam logic [11:0] PDOA_OFS_INT_MASK = 12'h00C;
	// Control fields and reset
	localparam int PDOA_CTRL_MON_EN = 0;
	localparam logic PDOA_CTRL_RST = 1'h1;
	// Event bits, shared by status and mask
	localparam int PDOA_NEV = 6;
	localparam int EV_OCH = 0;
	localparam int EV_ODI = 1;
	localparam int EV_OCU = 2;
	localparam int EV_SCD = 3;
	localparam int EV_XCH = 4;
	localparam int EV_STBY = 5;
	localparam logic [PDOA_NEV-1:0] PDOA_MASK_RST = 6'h00;
endpackage
`default_nettype wire

// ===== hdl/pdoa_qual.sv
// Delay qualifier: counts while its condition holds, restarts when it drops
`default_nettype none
module pdoa_qual
	import pdoa_pkg::*;
#(
	parameter int CW = PDOA_CW
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic [CW-1:0] limit_i,
	output logic done_o
);
	typedef struct packed {
		logic [CW-1:0] cnt;
	} pdoa_qst_t;
	pdoa_qst_t st_r;
	pdoa_qst_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (!run_i || done_o) begin
			st_nxt.cnt = '0;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end
	// Expiry pulse on the last counted cycle
	assign done_o = ce_i && run_i && (st_r.cnt == limit_i - 1'b1);
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/pdoa_irq.sv
// Sticky event status, mask and interrupt level
`default_nettype none
module pdoa_irq
	import pdoa_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [PDOA_NEV-1:0] event_i,
	input wire logic stat_wr_i,
	input wire logic mask_wr_i,
	input wire logic [PDOA_NEV-1:0] wdata_i,
	output logic [PDOA_NEV-1:0] stat_o,
	output logic [PDOA_NEV-1:0] mask_o,
	output logic irq_o
);
	typedef struct packed {
		logic [PDOA_NEV-1:0] stat;
		logic [PDOA_NEV-1:0] mask;
		logic irq;
	} pdoa_ist_t;
	pdoa_ist_t st_r;
	pdoa_ist_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		// Set wins over a write-one clear in the same cycle
		if (stat_wr_i) begin
			st_nxt.stat = st_r.stat & ~wdata_i;
		end
		st_nxt.stat = st_nxt.stat | event_i;
		if (mask_wr_i) begin
			st_nxt.mask = wdata_i;
		end
		st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
	end
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			st_r <= {{PDOA_NEV{1'b0}}, PDOA_MASK_RST, 1'b0};
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end
	assign stat_o = st_r.stat;
	assign mask_o = st_r.mask;
	assign irq_o = st_r.irq;
endmodule
`default_nettype wire

// ===== hdl/pdoa_top.sv
// Detection overlap arbiter with gate, standby and sense-node switch control
//
// Local design decisions: the placing of the registers and the APB register port.
`default_nettype none
module pdoa_top
	import pdoa_pkg::*;
#(
	parameter int DLY_CYC [PDOA_NCH] = PDOA_DLY_CYC
) (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic och_cmp_i,
	input wire logic odi_cmp_i,
	input wire logic ocu_cmp_i,
	input wire logic scd_cmp_i,
	input wire logic xch_cmp_i,
	input wire logic stby_rel_cmp_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic chg_gate_o,
	output logic dis_gate_o,
	output logic standby_o,
	output logic pullup_en_o,
	output logic pulldn_en_o,
	output logic irq_o
);
	typedef struct packed {
		logic och;
		logic odi;
		logic ocu;
		logic scd;
		logic xch;
		logic stby;
		logic chg_gate;
		logic dis_gate;
		logic pu;
		logic pd;
		logic mon_en;
		logic [31:0] rdata;
	} pdoa_st_t;

	pdoa_st_t st_r;
	pdoa_st_t st_nxt;
	logic [PDOA_NCH-1:0] run;
	logic [PDOA_NCH-1:0] done;
	logic mon;
	logic setup;
	logic access;
	logic hit;
	logic stat_wr;
	logic mask_wr;
	logic [PDOA_NEV-1:0] events;
	logic [PDOA_NEV-1:0] int_stat;
	logic [PDOA_NEV-1:0] int_mask;

	// Monitoring is suspended in standby
	assign mon = st_r.mon_en && !st_r.stby;

	// Qualifier run conditions
	always_comb begin
		run = '0;
		run[CH_OCH_D] = mon && och_cmp_i && !st_r.och;
		run[CH_OCH_R] = mon && st_r.och && !och_cmp_i;
		run[CH_ODI_D] = mon && odi_cmp_i && !st_r.odi && !run[CH_OCH_D];
		run[CH_ODI_R] = mon && st_r.odi && !odi_cmp_i;
		run[CH_OCU_D] = mon && ocu_cmp_i && !st_r.ocu && !st_r.och && !st_r.odi;
		run[CH_SCD_D] = mon && scd_cmp_i && !st_r.scd;
		run[CH_OCU_R] = mon && (st_r.ocu || st_r.scd) && !ocu_cmp_i && !scd_cmp_i;
		run[CH_XCH_D] = mon && xch_cmp_i && !st_r.xch && st_r.dis_gate
			&& !st_r.odi && !st_r.ocu && !st_r.scd;
		run[CH_XCH_R] = mon && st_r.xch && !xch_cmp_i;
	end

	// One delay qualifier per channel
	for (genvar g = 0; g < PDOA_NCH; g++) begin : g_ch
		pdoa_qual #(
			.CW(PDOA_CW)
		) u_qual (
			.core_clk_i(core_clk_i),
			.reset_n_i(reset_n_i),
			.ce_i(ce_i),
			.run_i(run[g]),
			.limit_i(PDOA_CW'(DLY_CYC[g])),
			.done_o(done[g])
		);
	end

	// Bus decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit = (paddr == PDOA_OFS_CTRL) || (paddr == PDOA_OFS_STATE)
		|| (paddr == PDOA_OFS_INT_STAT) || (paddr == PDOA_OFS_INT_MASK);
	assign stat_wr = access && pwrite && (paddr == PDOA_OFS_INT_STAT);
	assign mask_wr = access && pwrite && (paddr == PDOA_OFS_INT_MASK);

	// State update
	always_comb begin
		st_nxt = st_r;
		if (done[CH_OCH_D]) begin
			st_nxt.och = 1'b1;
		end
		if (done[CH_OCH_R]) begin
			st_nxt.och = 1'b0;
		end
		if (done[CH_ODI_D]) begin
			st_nxt.odi = 1'b1;
			st_nxt.stby = !st_r.och;
		end
		if (done[CH_ODI_R]) begin
			st_nxt.odi = 1'b0;
		end
		if (done[CH_OCU_D]) begin
			st_nxt.ocu = 1'b1;
		end
		if (done[CH_SCD_D]) begin
			st_nxt.scd = 1'b1;
		end
		if (done[CH_OCU_R]) begin
			st_nxt.ocu = 1'b0;
			st_nxt.scd = 1'b0;
		end
		if (done[CH_XCH_D]) begin
			st_nxt.xch = 1'b1;
		end
		if (done[CH_XCH_R]) begin
			st_nxt.xch = 1'b0;
		end
		// Charger pulls the sense node low and wakes the device
		if (st_r.stby && stby_rel_cmp_i) begin
			st_nxt.stby = 1'b0;
		end
		if (access && pwrite && (paddr == PDOA_OFS_CTRL)) begin
			st_nxt.mon_en = pwdata[PDOA_CTRL_MON_EN];
		end
		// Gate and switch outputs
		st_nxt.dis_gate = !(st_nxt.odi || st_nxt.ocu || st_nxt.scd);
		st_nxt.chg_gate = !(st_nxt.och || st_nxt.xch);
		st_nxt.pu = st_nxt.odi;
		st_nxt.pd = (st_nxt.ocu || st_nxt.scd) && !st_nxt.odi;
		// Read data is latched in the setup cycle
		if (setup) begin
			st_nxt.rdata = 32'h00000000;
			case (paddr)
				PDOA_OFS_CTRL: begin
					st_nxt.rdata[PDOA_CTRL_MON_EN] = st_r.mon_en;
				end
				PDOA_OFS_STATE: begin
					st_nxt.rdata[9:0] = {st_r.pd, st_r.pu, st_r.dis_gate, st_r.chg_gate,
						st_r.stby, st_r.xch, st_r.scd, st_r.ocu, st_r.odi, st_r.och};
				end
				PDOA_OFS_INT_STAT: begin
					st_nxt.rdata[PDOA_NEV-1:0] = int_stat;
				end
				PDOA_OFS_INT_MASK: begin
					st_nxt.rdata[PDOA_NEV-1:0] = int_mask;
				end
				default: begin
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
			st_r.chg_gate <= 1'b1;
			st_r.dis_gate <= 1'b1;
			st_r.mon_en <= PDOA_CTRL_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// Interrupt events
	assign events[EV_OCH] = done[CH_OCH_D];
	assign events[EV_ODI] = done[CH_ODI_D];
	assign events[EV_OCU] = done[CH_OCU_D];
	assign events[EV_SCD] = done[CH_SCD_D];
	assign events[EV_XCH] = done[CH_XCH_D];
	assign events[EV_STBY] = ce_i && st_nxt.stby && !st_r.stby;

	pdoa_irq u_irq (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.ce_i(ce_i),
		.event_i(events),
		.stat_wr_i(stat_wr && ce_i),
		.mask_wr_i(mask_wr && ce_i),
		.wdata_i(pwdata[PDOA_NEV-1:0]),
		.stat_o(int_stat),
		.mask_o(int_mask),
		.irq_o(irq_o)
	);

	// Outputs
	assign prdata = st_r.rdata;
	assign pready = ce_i;
	assign pslverr = access && !hit;
	assign chg_gate_o = st_r.chg_gate;
	assign dis_gate_o = st_r.dis_gate;
	assign standby_o = st_r.stby;
	assign pullup_en_o = st_r.pu;
	assign pulldn_en_o = st_r.pd;

	// Checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_odi_first;
		$rose(st_r.odi) && !$past(st_r.och) |-> standby_o && pullup_en_o && !dis_gate_o;
	endproperty
	a_odi_first: assert property (p_odi_first) else $error("standby or pull-up missing");

	property p_ocu_conf;
		$rose(st_r.ocu) && !st_r.odi |-> !dis_gate_o && pulldn_en_o && !pullup_en_o;
	endproperty
	a_ocu_conf: assert property (p_ocu_conf) else $error("over-current outputs wrong");

	property p_xch_gate;
		done[CH_XCH_D] && ce_i |=> !chg_gate_o;
	endproperty
	a_xch_gate: assert property (p_xch_gate) else $error("charge gate stayed high");

	property p_och_par;
		mon && och_cmp_i && !st_r.och && st_r.ocu |-> run[CH_OCH_D];
	endproperty
	a_och_par: assert property (p_och_par) else $error("over-charge count stalled");

	property p_ocu_block;
		(st_r.och || st_r.odi) |-> !run[CH_OCU_D];
	endproperty
	a_ocu_block: assert property (p_ocu_block) else $error("over-current count ran");

	property p_odi_abort;
		run[CH_OCH_D] |-> !run[CH_ODI_D];
	endproperty
	a_odi_abort: assert property (p_odi_abort) else $error("over-discharge not aborted");

	property p_odi_after_och;
		$rose(st_r.odi) && $past(st_r.och) |-> !standby_o && pullup_en_o;
	endproperty
	a_odi_after_och: assert property (p_odi_after_och) else $error("standby after over-charge");

	property p_swap;
		$rose(st_r.odi) && $past(st_r.ocu) && !$past(st_r.och) |-> !pulldn_en_o && standby_o;
	endproperty
	a_swap: assert property (p_swap) else $error("pull-down not swapped");

	property p_xch_inhibit;
		(st_r.odi || st_r.ocu || st_r.scd || !dis_gate_o) |-> !run[CH_XCH_D];
	endproperty
	a_xch_inhibit: assert property (p_xch_inhibit) else $error("charger count ran");

	property p_no_both;
		!(pullup_en_o && pulldn_en_o);
	endproperty
	a_no_both: assert property (p_no_both) else $error("both resistors enabled");

	property p_och_open;
		st_r.och && !st_r.ocu && !st_r.scd && !st_r.odi |-> !pullup_en_o && !pulldn_en_o;
	endproperty
	a_och_open: assert property (p_och_open) else $error("sense node not left open");

	property p_odi_resume;
		$rose(st_r.och) && mon && odi_cmp_i && !st_r.odi |-> run[CH_ODI_D];
	endproperty
	a_odi_resume: assert property (p_odi_resume) else $error("over-discharge not resumed");

	property p_odi_par;
		st_r.ocu && mon && odi_cmp_i && !st_r.odi && !st_r.och && !och_cmp_i |-> run[CH_ODI_D];
	endproperty
	a_odi_par: assert property (p_odi_par) else $error("over-discharge count stalled");

	property p_ocu_after_odi;
		st_r.odi |=> !$rose(st_r.ocu);
	endproperty
	a_ocu_after_odi: assert property (p_ocu_after_odi) else $error("over-current set");

	property p_scd_free;
		mon && scd_cmp_i && !st_r.scd |-> run[CH_SCD_D];
	endproperty
	a_scd_free: assert property (p_scd_free) else $error("short count held off");

	property p_xch_dis_low;
		!dis_gate_o |=> !$rose(st_r.xch);
	endproperty
	a_xch_dis_low: assert property (p_xch_dis_low) else $error("charger set, gate low");

	property p_restart;
		(!run[CH_OCU_D] && ce_i) ##1 run[CH_OCU_D]
			|-> (!done[CH_OCU_D] || (DLY_CYC[CH_OCU_D] == 1));
	endproperty
	a_restart: assert property (p_restart) else $error("count did not restart");

	property p_xch_rel;
		done[CH_XCH_R] && !st_r.och && !done[CH_OCH_D] |=> chg_gate_o;
	endproperty
	a_xch_rel: assert property (p_xch_rel) else $error("charge gate not restored");

	property p_scd_conf;
		$rose(st_r.scd) |-> !dis_gate_o && !standby_o;
	endproperty
	a_scd_conf: assert property (p_scd_conf) else $error("short outputs wrong");

	property p_stby_hold;
		standby_o |-> (done == '0);
	endproperty
	a_stby_hold: assert property (p_stby_hold) else $error("count ran in standby");

	property p_odi_nopd;
		st_r.odi |-> !pulldn_en_o;
	endproperty
	a_odi_nopd: assert property (p_odi_nopd) else $error("pull-down kept");

	property p_odi_pu;
		st_r.odi |-> pullup_en_o;
	endproperty
	a_odi_pu: assert property (p_odi_pu) else $error("pull-up missing");

	c_ocu_then_odi: cover property ($rose(st_r.odi) && st_r.ocu);
	c_och_then_odi: cover property ($rose(st_r.odi) && st_r.och);
	c_xch: cover property ($rose(st_r.xch));
	c_wake: cover property ($fell(st_r.stby));
	c_och_during_ocu: cover property ($rose(st_r.och) && st_r.ocu);
endmodule
`default_nettype wire

// ===== sim/pdoa_cmp_model.sv
// Comparator front end model: bench-set levels settle after one clock
`default_nettype none
module pdoa_cmp_model (
	input wire logic core_clk_i,
	input wire logic [5:0] cond_i,
	output logic och_cmp_o,
	output logic odi_cmp_o,
	output logic ocu_cmp_o,
	output logic scd_cmp_o,
	output logic xch_cmp_o,
	output logic stby_rel_cmp_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] lvl_r;
	always_ff @(posedge core_clk_i) begin
		lvl_r <= cond_i;
	end
	assign {stby_rel_cmp_o, xch_cmp_o, scd_cmp_o, ocu_cmp_o, odi_cmp_o, och_cmp_o} = lvl_r;
endmodule
`default_nettype wire

// ===== sim/pdoa_top_bench.sv
// Self-checking bench for the detection overlap arbiter
`default_nettype none
module pdoa_top_bench;
	import pdoa_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DLY [PDOA_NCH] = '{6, 6, 5, 6, 8, 4, 6, 6, 6};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] cond = 6'h00;
	logic och, odi, ocu, scd, xch, rel;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, chg, dis, stby, pu, pd, irq, err;
	logic [5:0] msk;
	logic ce = 1'b1;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 32'hF1C88EA8;
	int exp_stat;
	always #(PDOA_CLK_NS / 2) clk = ~clk;
	pdoa_cmp_model cmp (.core_clk_i(clk), .cond_i(cond), .och_cmp_o(och), .odi_cmp_o(odi),
		.ocu_cmp_o(ocu), .scd_cmp_o(scd), .xch_cmp_o(xch), .stby_rel_cmp_o(rel));
	pdoa_top #(.DLY_CYC(DLY)) uut (.core_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
		.och_cmp_i(och), .odi_cmp_i(odi), .ocu_cmp_i(ocu), .scd_cmp_i(scd), .xch_cmp_i(xch),
		.stby_rel_cmp_i(rel), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chg_gate_o(chg), .dis_gate_o(dis), .standby_o(stby), .pullup_en_o(pu),
		.pulldn_en_o(pd), .irq_o(irq));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	// Comparator levels held for w cycles, then gate/standby/switch outputs compared
	task automatic st(input logic [5:0] c, input int w, input logic [4:0] e);
		cond <= c;
		repeat (w) @(posedge clk);
		@(negedge clk);
		check("outputs", {27'h0, e}, {27'h0, chg, dis, stby, pu, pd});
		@(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, PDOA_OFS_CTRL, 32'h0);
		check("ctrl", {31'h0, PDOA_CTRL_RST}, rd);
		apb(1'b0, PDOA_OFS_INT_MASK, 32'h0);
		check("mask", {26'h0, PDOA_MASK_RST}, rd);
		msk = 6'($random(seed));
		msk[EV_OCH] = 1'b1;
		apb(1'b1, PDOA_OFS_INT_MASK, {26'h0, msk});
		apb(1'b0, PDOA_OFS_INT_MASK, 32'h0);
		check("mask", {26'h0, msk}, rd);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		check("slverr", 32'h1, {31'h0, err});
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", 32'h1, {rd[30:0], err});
		st(6'h00, 2, 5'h18);
		st(6'h04, 5, 5'h18);
		st(6'h00, 2, 5'h18);
		st(6'h04, 5, 5'h18);
		st(6'h04, 4, 5'h11);
		st(6'h06, 8, 5'h16);
		apb(1'b0, PDOA_OFS_STATE, 32'h0);
		check("state", 32'h166, rd);
		st(6'h20, 40, 5'h18);
		st(6'h00, 2, 5'h18);
		st(6'h02, 8, 5'h16);
		st(6'h26, 12, 5'h12);
		apb(1'b0, PDOA_OFS_STATE, 32'h0);
		check("state", 32'h142, rd);
		st(6'h20, 40, 5'h18);
		st(6'h00, 2, 5'h18);
		st(6'h01, 9, 5'h08);
		st(6'h05, 12, 5'h08);
		st(6'h00, 20, 5'h18);
		st(6'h04, 11, 5'h11);
		st(6'h05, 9, 5'h01);
		st(6'h00, 30, 5'h18);
		st(6'h02, 3, 5'h18);
		st(6'h03, 9, 5'h08);
		st(6'h03, 8, 5'h02);
		st(6'h00, 30, 5'h18);
		st(6'h08, 7, 5'h11);
		st(6'h00, 20, 5'h18);
		st(6'h01, 9, 5'h08);
		st(6'h09, 7, 5'h01);
		st(6'h00, 20, 5'h18);
		st(6'h04, 11, 5'h11);
		st(6'h14, 12, 5'h11);
		st(6'h10, 9, 5'h18);
		st(6'h10, 9, 5'h08);
		st(6'h00, 9, 5'h18);
		exp_stat = (1 << EV_OCH) | (1 << EV_ODI) | (1 << EV_OCU) | (1 << EV_SCD);
		exp_stat = exp_stat | (1 << EV_XCH) | (1 << EV_STBY);
		apb(1'b0, PDOA_OFS_INT_STAT, 32'h0);
		check("int_stat", 32'(exp_stat), rd);
		check("irq", 32'h1, {31'h0, irq});
		apb(1'b1, PDOA_OFS_INT_MASK, 32'h0);
		repeat (2) @(posedge clk);
		check("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, PDOA_OFS_INT_MASK, {26'h0, msk});
		apb(1'b1, PDOA_OFS_INT_STAT, 32'h3F);
		apb(1'b0, PDOA_OFS_INT_STAT, 32'h0);
		check("int_stat clr", 32'h0, rd);
		repeat (2) @(posedge clk);
		check("irq clr", 32'h0, {31'h0, irq});
		apb(1'b1, PDOA_OFS_CTRL, 32'h0);
		apb(1'b0, PDOA_OFS_CTRL, 32'h0);
		check("ctrl off", 32'h0, rd);
		st(6'h04, 12, 5'h18);
		st(6'h00, 2, 5'h18);
		apb(1'b1, PDOA_OFS_CTRL, 32'h1);
		ce <= 1'b0;
		st(6'h01, 12, 5'h18);
		ce <= 1'b1;
		st(6'h00, 2, 5'h18);
		final_report();
	end
endmodule
`default_nettype wire
